// >>> testbench/flow_chain_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "flow_defines.svh"
module flow_chain_asserts (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Stream and settings
	input wire logic sample_valid,
	input wire logic sample_ready,
	input wire flow_pkg::sample_type sample_data,
	input wire logic cfg_load,
	input wire flow_pkg::config_type cfg_data,
	input wire logic offset_start,
	// Status and results
	input wire logic [`UNIT_W-1:0] unit_code,
	input wire logic unit_rejected,
	input wire logic offset_busy,
	input wire logic signed [`FLOW_W-1:0] offset_value,
	input wire logic flow_strobe,
	input wire logic signed [`FLOW_W-1:0] flow_out,
	input wire logic zero_flow,
	input wire logic signed [`TOT_W-1:0] total_out,
	input wire logic freq_out,
	input wire logic signed [`FLOW_W-1:0] display_out
);
	import flow_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	AST_STROBE_PULSE: assert property (flow_strobe |=> !flow_strobe)
		else $error("flow_strobe wider than one cycle");
	// Bound covers a full FIFO ahead of the sample in volume mode
	AST_LATENCY: assert property (sample_valid && sample_ready
		|-> ##[1:700] flow_strobe) else $error("sample gave no result");
	AST_STAND: assert property (!flow_strobe |-> $stable(flow_out)
		&& $stable(total_out)) else $error("result moved without strobe");
	AST_TOTAL_SUM: assert property (flow_strobe && !zero_flow
		|-> total_out == $past(total_out) + flow_out)
		else $error("total not advanced by flow");
	AST_CUT_ZERO: assert property (zero_flow
		|-> flow_out == 0 && display_out == 0) else $error("cut not zero");
	AST_CUT_HOLD: assert property (flow_strobe && zero_flow
		|-> $stable(total_out)) else $error("total moved under cut");
	AST_FREQ_BIT: assert property (freq_out == total_out[20])
		else $error("freq_out not following total");
	AST_UNIT_CLASS: assert property (cfg_load
		|=> unit_code[`UNIT_CLASS_BIT] == $past(cfg_data.volume_mode))
		else $error("unit class differs from mode");
	AST_UNIT_REJECT: assert property (cfg_load |=> unit_rejected ==
		($past(cfg_data.unit_code[3]) != $past(cfg_data.volume_mode)))
		else $error("unit reject pulse wrong");
	AST_OFFSET_BUSY: assert property (offset_start && !offset_busy
		|=> offset_busy) else $error("offset run not started");
	cover property (flow_strobe && zero_flow);
	cover property (flow_strobe && !zero_flow);
	cover property (unit_rejected);
	cover property ($fell(offset_busy));
endmodule : flow_chain_asserts
`default_nettype wire

// >>> testbench/flow_sensor_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "flow_defines.svh"
module flow_sensor_model (
	// Clock
	input wire logic clock,
	// Sample stream
	input wire logic sample_ready,
	output var logic sample_valid,
	output var flow_pkg::sample_type sample_data
);
	import flow_pkg::*;
	initial begin
		sample_valid = 1'b0;
		sample_data = '0;
	end
	// Waits gap + 1 clock edges, then holds one sample until the edge that takes it
	task automatic send(input logic signed [`FLOW_W-1:0] m,
		input logic [`DENS_W-1:0] d, input int gap, output bit ok);
		int n;
		ok = 0;
		repeat (gap + 1) @(posedge clock);
		#1;
		sample_valid = 1'b1;
		sample_data = '{m, d};
		for (n = 0; n < 2000 && !ok; n++) begin
			@(posedge clock);
			ok = (sample_ready === 1'b1);
		end
		#1;
		sample_valid = 1'b0;
		// Released lines are scrambled so nothing leans on a stale sample
		sample_data = ~sample_data;
	endtask : send
endmodule : flow_sensor_model
`default_nettype wire

// >>> testbench/tb_flow_filter_cutoff_chain.sv
`timescale 1ns/10ps
`default_nettype none
`include "flow_defines.svh"
module tb_flow_filter_cutoff_chain;
	import flow_pkg::*;
	logic clock = 0;
	logic reset = 1;
	logic cfg_load = 0;
	config_type cfg_data = '0;
	logic offset_start = 0;
	logic sample_valid, sample_ready, unit_rejected, offset_busy;
	logic flow_strobe, zero_flow, freq_out;
	logic saw_full = 0;
	sample_type sample_data;
	logic [`UNIT_W-1:0] unit_code;
	logic signed [`FLOW_W-1:0] offset_value, flow_out, display_out;
	logic signed [`TOT_W-1:0] total_out, tot0;
	int bad_count = 0;
	int checks = 0;
	int strobes = 0;
	always #4 clock = ~clock;
	always @(posedge clock) begin
		if (flow_strobe === 1'b1) strobes <= strobes + 1;
		if (sample_valid && sample_ready === 1'b0) saw_full <= 1'b1;
	end
	flow_sensor_model sensor (.clock(clock), .sample_ready(sample_ready),
		.sample_valid(sample_valid), .sample_data(sample_data));
	flow_filter_cutoff_chain dut (.clock(clock), .reset(reset),
		.sample_valid(sample_valid), .sample_ready(sample_ready),
		.sample_data(sample_data), .cfg_load(cfg_load),
		.cfg_data(cfg_data), .offset_start(offset_start),
		.unit_code(unit_code), .unit_rejected(unit_rejected),
		.offset_busy(offset_busy), .offset_value(offset_value),
		.flow_strobe(flow_strobe), .flow_out(flow_out),
		.zero_flow(zero_flow), .total_out(total_out),
		.freq_out(freq_out), .display_out(display_out));
	task automatic end_of_test();
		if (bad_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	task automatic timeout(input string name);
		bad_count++;
		$display("[ERR] %s expected done seen timeout", name);
		end_of_test();
	endtask : timeout
	task automatic check_val(input string name, input logic signed [47:0] e,
		input logic signed [47:0] s);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %0d seen %0d", name, e, s);
		end
	endtask : check_val
	task automatic check_range(input string name, input int lo, input int hi,
		input logic signed [47:0] s);
		checks++;
		if ($isunknown(s) || s < lo || s > hi) begin
			bad_count++;
			$display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, s);
		end
	endtask : check_range
	task automatic load(input logic [15:0] fc, dc, input logic [23:0] lo, jt,
		input logic vm, input logic [3:0] uc);
		@(posedge clock);
		#1;
		cfg_data = '{fc, dc, lo, jt, vm, uc};
		cfg_load = 1'b1;
		@(posedge clock);
		#1;
		cfg_load = 1'b0;
	endtask : load
	task automatic put(input logic signed [23:0] m, input logic [15:0] d);
		bit ok;
		int n;
		sensor.send(m, d, 2, ok);
		if (!ok) timeout("sample_ready");
		for (n = 0; n < 100; n++) begin
			@(posedge clock);
			#1;
			if (flow_strobe === 1'b1) break;
		end
		if (n == 100) timeout("flow_strobe");
	endtask : put
	task automatic t_defaults();
		check_val("zero_flow", 1, zero_flow);
		put(24'h3f52f0, 16'h1000);
		check_val("zero_flow", 1, zero_flow);
		check_val("flow_out", 0, flow_out);
		put(24'h7ea5e0, 16'h1000);
		check_val("flow_out", 48'h7ea5e0, flow_out);
		check_val("total_out", 48'h7ea5e0, total_out);
		check_val("freq_out", 1, freq_out);
	endtask : t_defaults
	task automatic t_decay();
		load(16'h028f, 16'hffff, 24'h000064, 24'h0003e8, 1'b0, 4'h1);
		put(24'h00c350, 16'h1000);
		check_val("flow_out", 48'h00c350, flow_out);
		load(16'h028f, 16'h0148, 24'h000064, 24'h3f5c28, 1'b0, 4'h1);
		put(24'h000000, 16'h1000);
		check_range("flow_out", 49499, 49501, flow_out);
		repeat (99) put(24'h000000, 16'h1000);
		check_range("flow_out", 50000*98/272, 50000*102/272, flow_out);
		check_val("display_lag", 1, display_out > flow_out);
	endtask : t_decay
	task automatic t_cut();
		load(16'h028f, 16'h0148, 24'h004e20, 24'h3f5c28, 1'b0, 4'h1);
		tot0 = total_out;
		put(24'h000000, 16'h1000);
		check_val("zero_flow", 1, zero_flow);
		check_val("display_out", 0, display_out);
		check_val("total_out", tot0, total_out);
	endtask : t_cut
	task automatic t_units();
		logic vm[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		logic [3:0] uc[5] = '{4'h9, 4'h2, 4'hc, 4'h3, 4'ha};
		logic [3:0] eu[5] = '{4'h9, 4'h9, 4'h0, 4'h3, 4'ha};
		logic er[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		for (int i = 0; i < 5; i++) begin
			load(16'h028f, 16'h0148, 24'h000064, 24'h0003e8, vm[i], uc[i]);
			check_val("unit_code", eu[i], unit_code);
			check_val("unit_rejected", er[i], unit_rejected);
		end
		put(24'h00a000, 16'h2000);
		check_val("volume_flow", 48'h005000, flow_out);
	endtask : t_units
	task automatic t_burst();
		bit ok;
		int n;
		int s0;
		s0 = strobes;
		saw_full = 1'b0;
		// Chain is far slower than the offers in volume mode, so FIFO fills
		for (n = 0; n < 20; n++) begin
			sensor.send(24'h00a000, 16'h1000, 0, ok);
			if (!ok) timeout("sample_ready");
		end
		for (n = 0; n < 2000 && strobes - s0 < 20; n++) @(posedge clock);
		#1;
		check_val("result_count", 20, strobes - s0);
		check_val("fifo_full", 1, saw_full);
		check_val("volume_flow", 48'h00a000, flow_out);
	endtask : t_burst
	task automatic t_offset();
		load(16'h028f, 16'h0148, 24'h000064, 24'h0003e8, 1'b0, 4'h1);
		offset_start = 1'b1;
		@(posedge clock);
		#1;
		offset_start = 1'b0;
		check_val("offset_busy", 1, offset_busy);
		repeat (16) put(24'h0003e8, 16'h1000);
		check_val("offset_busy", 0, offset_busy);
		check_val("offset_value", 48'h0003e8, offset_value);
		put(24'h001770, 16'h1000);
		check_val("flow_out", 48'h001388, flow_out);
	endtask : t_offset
	initial begin
		repeat (16) @(posedge clock);
		#1;
		reset = 1'b0;
		t_defaults();
		t_decay();
		t_cut();
		t_units();
		t_burst();
		t_offset();
		end_of_test();
	end
endmodule : tb_flow_filter_cutoff_chain
bind flow_filter_cutoff_chain flow_chain_asserts chk (.clock(clock),
	.reset(reset), .sample_valid(sample_valid), .sample_ready(sample_ready),
	.sample_data(sample_data), .cfg_load(cfg_load), .cfg_data(cfg_data),
	.offset_start(offset_start), .unit_code(unit_code),
	.unit_rejected(unit_rejected), .offset_busy(offset_busy),
	.offset_value(offset_value), .flow_strobe(flow_strobe),
	.flow_out(flow_out), .zero_flow(zero_flow), .total_out(total_out),
	.freq_out(freq_out), .display_out(display_out));
`default_nettype wire

// >>> verilog/flow_defines.svh
`ifndef FLOW_DEFINES_SVH
`define FLOW_DEFINES_SVH
`define FLOW_W 24
`define DENS_W 16
`define COEF_W 16
`define FRAC_W 16
`define TOT_W 48
`define VOL_SHIFT 12
`define UNIT_W 4
`define UNIT_CLASS_BIT 3
`define CUT_PERMILLE 3
`define JUMP_PERCENT 99
`define TAU_DEFAULT_US 1000000
`define OFS_LOG2 4
`define PULSE_BIT 20
`define FIFO_DEPTH 16
`endif

// >>> verilog/flow_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module flow_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] count_reg, count_next;
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic ready_reg, ready_next;
	logic push, pop;
	assign push = in_valid && ready_reg;
	assign pop = out_ready && (count_reg != '0);
	assign in_ready = ready_reg;
	assign out_valid = count_reg != '0;
	assign out_data = mem[rd_reg];
	always_comb begin
		wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		count_next = count_reg;
		if (push && !pop)
			count_next = (AW+1)'(count_reg + 1'b1);
		else if (pop && !push)
			count_next = (AW+1)'(count_reg - 1'b1);
		// Registered ready from the next count, so all DEPTH slots stay usable
		ready_next = count_next < (AW+1)'(DEPTH);
	end
	always_ff @(posedge clock) begin
		if (push)
			mem[wr_reg] <= in_data;
		if (reset) begin
			count_reg <= '0;
			wr_reg <= '0;
			rd_reg <= '0;
			ready_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			ready_reg <= ready_next;
		end
	end
endmodule : flow_fifo
`default_nettype wire

// >>> verilog/flow_filter_cutoff_chain.sv
// Overview of operation
// - Flow filter is first order; step to zero falls to x/2.72 after one tau.
// - Flow filter acts before the total and the rate outputs; 1 s advised.
// - Display filter follows the flow filter, feeds only the readout, 1 s.
// - Smoothing is linear so returning flow leaves total and pulses unchanged.
// - Filtered flow below threshold reports zero, holds total, zeroes outputs.
// - Low flow threshold defaults to 0.3 percent of full scale.
// - Difference below jump threshold keeps normal filtering.
// - Difference above jump threshold reloads filter with the new sample.
// - Jump threshold defaults to 99 percent of full scale.
// - Mass mode offers only mass units, volume mode only volume units.
// - Mass flow and density are measured; volume flow derived in volume mode.
// - Offset adjustment learns zero offset, then subtracts it from every sample.
`timescale 1ns/10ps
`default_nettype none
`include "flow_defines.svh"
module flow_filter_cutoff_chain #(
	parameter int FULL_SCALE = 4194304,
	parameter int SAMPLE_PERIOD_US = 1000,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Sample stream
	input wire logic sample_valid,
	output logic sample_ready,
	input wire flow_pkg::sample_type sample_data,
	// Settings
	input wire logic cfg_load,
	input wire flow_pkg::config_type cfg_data,
	input wire logic offset_start,
	// Settings status
	output logic [`UNIT_W-1:0] unit_code,
	output logic unit_rejected,
	output logic offset_busy,
	output logic signed [`FLOW_W-1:0] offset_value,
	// Results
	output logic flow_strobe,
	output logic signed [`FLOW_W-1:0] flow_out,
	output logic zero_flow,
	output logic signed [`TOT_W-1:0] total_out,
	output logic freq_out,
	output logic signed [`FLOW_W-1:0] display_out
);
	import flow_pkg::*;
	localparam int FW = `FLOW_W;
	localparam int DW = `DENS_W;
	localparam int CW = `COEF_W;
	localparam int QW = `FLOW_W + `FRAC_W;
	localparam int TW = `TOT_W;
	localparam int NW = `FLOW_W + `VOL_SHIFT;
	localparam int OL = `OFS_LOG2;
	localparam longint COEF_DEF =
		(longint'(1) << CW) * SAMPLE_PERIOD_US / `TAU_DEFAULT_US;
	localparam longint CUT_DEF =
		longint'(FULL_SCALE) * `CUT_PERMILLE / 1000;
	localparam longint JUMP_DEF =
		longint'(FULL_SCALE) * `JUMP_PERCENT / 100;
	localparam logic signed [FW-1:0] MAX_POS = {1'b0, {(FW-1){1'b1}}};
	localparam logic signed [FW-1:0] MAX_NEG = {1'b1, {(FW-1){1'b0}}};
	function automatic logic [FW-1:0] mag(input logic signed [FW-1:0] v);
		logic [FW:0] w;
		w = v[FW-1] ? (FW+1)'(-(FW+1)'(v)) : (FW+1)'(v);
		mag = w[FW] ? {FW{1'b1}} : w[FW-1:0];
	endfunction : mag
	function automatic logic signed [FW-1:0] sat(
		input logic signed [FW:0] v);
		if (v > (FW+1)'(MAX_POS))
			sat = MAX_POS;
		else if (v < (FW+1)'(MAX_NEG))
			sat = MAX_NEG;
		else
			sat = v[FW-1:0];
	endfunction : sat
	// One first order step, with optional reload on a large jump
	function automatic logic signed [QW-1:0] filt_step(
		input logic signed [QW-1:0] y,
		input logic signed [FW-1:0] x,
		input logic [CW-1:0] coef,
		input logic [FW-1:0] thr);
		logic signed [QW:0] d;
		logic [QW:0] dm;
		logic signed [QW+CW+1:0] p;
		logic signed [QW-1:0] xq;
		xq = $signed({x, {`FRAC_W{1'b0}}});
		d = (QW+1)'(xq) - (QW+1)'(y);
		dm = d[QW] ? (QW+1)'(-d) : d;
		p = d * $signed({1'b0, coef});
		if (dm[QW:`FRAC_W] > {1'b0, thr})
			filt_step = xq;
		else
			filt_step = y + QW'(p >>> CW);
	endfunction : filt_step
	// Sample buffer between the front end and the chain
	sample_type fifo_data;
	logic fifo_valid, pop;
	flow_fifo #(.WIDTH($bits(sample_type)), .DEPTH(FIFO_DEPTH)) fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.in_data(sample_data),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);
	// Settings
	config_type cfg_reg, cfg_next;
	logic [`UNIT_W-1:0] unit_reg, unit_next;
	logic reject_reg, reject_next;
	always_comb begin
		cfg_next = cfg_reg;
		unit_next = unit_reg;
		reject_next = 1'b0;
		if (cfg_load) begin
			cfg_next = cfg_data;
			// Units of the other class are refused so totals keep meaning
			if (cfg_data.unit_code[`UNIT_CLASS_BIT] == cfg_data.volume_mode)
				unit_next = cfg_data.unit_code;
			else begin
				reject_next = 1'b1;
				if (unit_reg[`UNIT_CLASS_BIT] != cfg_data.volume_mode)
					unit_next = {cfg_data.volume_mode, 3'h0};
			end
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			cfg_reg.flow_coef <= CW'(COEF_DEF);
			cfg_reg.disp_coef <= CW'(COEF_DEF);
			cfg_reg.low_flow_threshold <= FW'(CUT_DEF);
			cfg_reg.jump_bypass_threshold <= FW'(JUMP_DEF);
			cfg_reg.volume_mode <= 1'b0;
			cfg_reg.unit_code <= 4'h0;
			unit_reg <= 4'h0;
			reject_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			unit_reg <= unit_next;
			reject_reg <= reject_next;
		end
	end
	// Offset adjustment: averages raw samples taken at no flow
	offset_state_type ofs_state_reg, ofs_state_next;
	logic [OL-1:0] ofs_cnt_reg, ofs_cnt_next;
	logic signed [FW+OL-1:0] ofs_sum_reg, ofs_sum_next;
	logic signed [FW-1:0] offset_reg, offset_next;
	always_comb begin
		ofs_state_next = ofs_state_reg;
		ofs_cnt_next = ofs_cnt_reg;
		ofs_sum_next = ofs_sum_reg;
		offset_next = offset_reg;
		case (ofs_state_reg)
			OFS_IDLE: begin
				if (offset_start) begin
					ofs_state_next = OFS_ACC;
					ofs_cnt_next = '0;
					ofs_sum_next = '0;
				end
			end
			OFS_ACC: begin
				if (pop) begin
					ofs_sum_next = ofs_sum_reg + (FW+OL)'(fifo_data.mass);
					ofs_cnt_next = OL'(ofs_cnt_reg + 1'b1);
					if (ofs_cnt_reg == {OL{1'b1}}) begin
						offset_next = FW'(ofs_sum_next >>> OL);
						ofs_state_next = OFS_IDLE;
					end
				end
			end
			default: ofs_state_next = OFS_IDLE;
		endcase
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			ofs_state_reg <= OFS_IDLE;
			ofs_cnt_reg <= '0;
			ofs_sum_reg <= '0;
			offset_reg <= '0;
		end else begin
			ofs_state_reg <= ofs_state_next;
			ofs_cnt_reg <= ofs_cnt_next;
			ofs_sum_reg <= ofs_sum_next;
			offset_reg <= offset_next;
		end
	end
	// Processing chain; the buffer is drained only while idle
	stage_type stage_reg, stage_next;
	logic signed [FW-1:0] x_reg, x_next;
	logic [DW-1:0] dens_reg, dens_next;
	logic [DW:0] rem_reg, rem_next;
	logic [NW-1:0] quot_reg, quot_next;
	logic [5:0] div_cnt_reg, div_cnt_next;
	logic neg_reg, neg_next;
	logic signed [QW-1:0] filt_reg, filt_next;
	logic signed [QW-1:0] disp_reg, disp_next;
	logic signed [TW-1:0] total_reg, total_next;
	logic signed [FW-1:0] flow_reg, flow_next;
	logic signed [FW-1:0] show_reg, show_next;
	logic zero_reg, zero_next;
	logic strobe_reg, strobe_next;
	logic freq_reg, freq_next;
	logic signed [FW-1:0] corr, yint, cut;
	logic [DW:0] trial;
	logic [NW:0] quot_sat;
	assign pop = fifo_valid && (stage_reg == ST_IDLE);
	assign corr = sat((FW+1)'(fifo_data.mass) - (FW+1)'(offset_reg));
	assign yint = filt_reg[QW-1:`FRAC_W];
	assign trial = {rem_reg[DW-1:0], quot_reg[NW-1]};
	assign quot_sat = {1'b0, quot_reg};
	always_comb begin
		stage_next = stage_reg;
		x_next = x_reg;
		dens_next = dens_reg;
		rem_next = rem_reg;
		quot_next = quot_reg;
		div_cnt_next = div_cnt_reg;
		neg_next = neg_reg;
		filt_next = filt_reg;
		disp_next = disp_reg;
		total_next = total_reg;
		flow_next = flow_reg;
		show_next = show_reg;
		zero_next = zero_reg;
		strobe_next = 1'b0;
		freq_next = freq_reg;
		cut = '0;
		case (stage_reg)
			ST_IDLE: begin
				if (pop) begin
					x_next = corr;
					dens_next = fifo_data.density;
					if (cfg_reg.volume_mode) begin
						neg_next = corr[FW-1];
						quot_next = {mag(corr), {`VOL_SHIFT{1'b0}}};
						rem_next = '0;
						div_cnt_next = '0;
						stage_next = ST_DIV;
					end else
						stage_next = ST_FILT;
				end
			end
			ST_DIV: begin
				// Restoring divide, one quotient bit a cycle
				if (trial >= {1'b0, dens_reg}) begin
					rem_next = trial - {1'b0, dens_reg};
					quot_next = {quot_reg[NW-2:0], 1'b1};
				end else begin
					rem_next = trial;
					quot_next = {quot_reg[NW-2:0], 1'b0};
				end
				div_cnt_next = 6'(div_cnt_reg + 1'b1);
				if (div_cnt_reg == 6'(NW)) begin
					rem_next = rem_reg;
					quot_next = quot_reg;
					// Zero density would divide by zero; pin to full rate
					if (dens_reg == '0 || quot_sat > (NW+1)'(MAX_POS))
						x_next = neg_reg ? -MAX_POS : MAX_POS;
					else
						x_next = neg_reg ? -FW'(quot_reg) : FW'(quot_reg);
					stage_next = ST_FILT;
				end
			end
			ST_FILT: begin
				filt_next = filt_step(filt_reg, x_reg, cfg_reg.flow_coef,
					cfg_reg.jump_bypass_threshold);
				stage_next = ST_OUT;
			end
			ST_OUT: begin
				if (mag(yint) < cfg_reg.low_flow_threshold) begin
					cut = '0;
					zero_next = 1'b1;
				end else begin
					cut = yint;
					zero_next = 1'b0;
				end
				// Plain sum keeps the total and the pulse train exact
				total_next = total_reg + TW'(cut);
				freq_next = total_next[`PULSE_BIT];
				flow_next = cut;
				disp_next = filt_step(disp_reg, cut, cfg_reg.disp_coef,
					{FW{1'b1}});
				show_next = zero_next ? '0 :
					disp_next[QW-1:`FRAC_W];
				strobe_next = 1'b1;
				stage_next = ST_IDLE;
			end
			default: stage_next = ST_IDLE;
		endcase
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			stage_reg <= ST_IDLE;
			x_reg <= '0;
			dens_reg <= '0;
			rem_reg <= '0;
			quot_reg <= '0;
			div_cnt_reg <= '0;
			neg_reg <= 1'b0;
			filt_reg <= '0;
			disp_reg <= '0;
			total_reg <= '0;
			flow_reg <= '0;
			show_reg <= '0;
			zero_reg <= 1'b1;
			strobe_reg <= 1'b0;
			freq_reg <= 1'b0;
		end else begin
			stage_reg <= stage_next;
			x_reg <= x_next;
			dens_reg <= dens_next;
			rem_reg <= rem_next;
			quot_reg <= quot_next;
			div_cnt_reg <= div_cnt_next;
			neg_reg <= neg_next;
			filt_reg <= filt_next;
			disp_reg <= disp_next;
			total_reg <= total_next;
			flow_reg <= flow_next;
			show_reg <= show_next;
			zero_reg <= zero_next;
			strobe_reg <= strobe_next;
			freq_reg <= freq_next;
		end
	end
	assign unit_code = unit_reg;
	assign unit_rejected = reject_reg;
	assign offset_busy = ofs_state_reg == OFS_ACC;
	assign offset_value = offset_reg;
	assign flow_strobe = strobe_reg;
	assign flow_out = flow_reg;
	assign zero_flow = zero_reg;
	assign total_out = total_reg;
	assign freq_out = freq_reg;
	assign display_out = show_reg;
endmodule : flow_filter_cutoff_chain
`default_nettype wire

// >>> verilog/flow_pkg.sv
`include "flow_defines.svh"
package flow_pkg;
	typedef struct packed {
		logic signed [`FLOW_W-1:0] mass;
		logic [`DENS_W-1:0] density;
	} sample_type;
	typedef struct packed {
		logic [`COEF_W-1:0] flow_coef;
		logic [`COEF_W-1:0] disp_coef;
		logic [`FLOW_W-1:0] low_flow_threshold;
		logic [`FLOW_W-1:0] jump_bypass_threshold;
		logic volume_mode;
		logic [`UNIT_W-1:0] unit_code;
	} config_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DIV = 2'b01,
		ST_FILT = 2'b10,
		ST_OUT = 2'b11
	} stage_type;
	typedef enum logic {
		OFS_IDLE = 1'b0,
		OFS_ACC = 1'b1
	} offset_state_type;
endpackage : flow_pkg
